// ==== design/mscsr_pkg.sv ====
// constants, field layouts and carrier types of the miscellaneous system register block
package mscsr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_PIN_CONFIG   = 8'h88;
  localparam logic [7:0] OFS_TIMER_CONFIG = 8'h8c;
  localparam logic [7:0] OFS_TIMER_COUNT  = 8'h90;
  localparam logic [7:0] OFS_WORD_ORDER   = 8'h98;
  localparam logic [7:0] OFS_TICK_COUNT   = 8'h9c;
  localparam logic [7:0] OFS_DROP_COUNT   = 8'ha0;

  // field positions
  localparam int PIN_DATA_LSB    = 0;
  localparam int PIN_ODATA_LSB   = 3;
  localparam int PIN_DIR_LSB     = 8;
  localparam int ROM_SEL_LSB     = 20;
  localparam int TIMER_RUN_BIT   = 29;

  // reset values and special patterns
  localparam logic [15:0] PRELOAD_RESET  = 16'hffff;
  localparam logic [15:0] COUNT_RESET    = 16'hffff;
  localparam logic [31:0] WORD_ORDER_RST = 32'h00000000;
  localparam logic [31:0] SWAP_PATTERN   = 32'hffffffff;
  localparam logic [31:0] DROP_HALF_FROM = 32'h07ffffff;
  localparam logic [31:0] DROP_HALF_TO   = 32'h08000000;

  // timing: system clock and tick rate
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int TICK_PERIOD_PS  = 40000;
  localparam int TICK_DIV        = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int TICK_CLEAR_NS   = 160;
  localparam int TICK_CLEAR_CYC  = (TICK_CLEAR_NS * 1000) / CLK_PERIOD_PS;

  // ROM pin select codes
  typedef enum logic [2:0] {
    ROM_SEL_ROM     = 3'h0,
    ROM_SEL_OUTS    = 3'h1,
    ROM_SEL_RES2    = 3'h2,
    ROM_SEL_OUT_RX  = 3'h3,
    ROM_SEL_RES4    = 3'h4,
    ROM_SEL_TX_OUT  = 3'h5,
    ROM_SEL_TX_RX   = 3'h6,
    ROM_SEL_CLOCKS  = 3'h7
  } mscsr_rom_sel_type;

  // timer states, one-hot
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b01,
    TMR_RUN  = 2'b10
  } mscsr_tmr_state_type;

  // stored pin configuration
  typedef struct packed {
    logic [2:0] pin_direction_bit;
    logic [1:0] output_only_data_bit;
    logic [2:0] pin_data_bit;
    logic [2:0] serial_rom_pin_select;
  } mscsr_pin_cfg_type;

  // one routed pin: level and enable
  typedef struct packed {
    logic level;
    logic enable;
  } mscsr_pin_drv_type;

endpackage

// ==== design/mscsr_tick.sv ====
// tick enable divider and free-running 32-bit tick counter
`timescale 1ns/1ps
`default_nettype none
module mscsr_tick #(
  parameter int DIV = mscsr_pkg::TICK_DIV
) (
  input  wire logic        clk,
  input  wire logic        srst,
  output logic             tick,
  output logic [31:0]      tick_count
);

  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;

  if (DIV < 2) begin : g_bad_div
    $error("mscsr_tick: DIV must be at least 2");
  end

  logic [DW-1:0] div_reg;
  logic [DW-1:0] div_next;
  logic          tick_reg;
  logic          tick_next;
  logic [31:0]   cnt_reg;
  logic [31:0]   cnt_next;

  // divider and counter; no power-state input, so it runs in D0, D1 and D2 alike
  always_comb begin
    tick_next = 1'b0;
    div_next  = div_reg + 1'b1;
    if (div_reg == DW'(DIV - 1)) begin
      div_next  = '0;
      tick_next = 1'b1;
    end
    cnt_next = cnt_reg;
    if (tick_reg) begin
      cnt_next = cnt_reg + 32'h00000001; // wraps through zero
    end
  end

  // synchronous reset clears at once, well inside the allowed settling time
  always_ff @(posedge clk) begin
    if (srst) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
      cnt_reg  <= 32'h00000000;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign tick       = tick_reg;
  assign tick_count = cnt_reg;

endmodule
`default_nettype wire

// ==== design/mscsr_top.sv ====
// miscellaneous system registers: pins, ROM pin routing, timer, word order, counters
`timescale 1ns/1ps
`default_nettype none
module mscsr_top #(
  parameter int TICK_DIV = mscsr_pkg::TICK_DIV
) (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        HOST_CS_N,
  input  wire logic        HOST_RD_N,
  input  wire logic        HOST_WR_N,
  input  wire logic [7:1]  HOST_ADDR,
  input  wire logic [15:0] HOST_DATA_IN,
  output logic [15:0]      HOST_DATA_OUT,
  output logic             HOST_DATA_OE,
  output logic             HOST_HALF_HI,
  input  wire logic [2:0]  GPIO_IN,
  output logic [2:0]       GPIO_OUT,
  output logic [2:0]       GPIO_OE,
  input  wire logic        ROM_CTRL_DATA,
  input  wire logic        ROM_CTRL_DATA_OE,
  input  wire logic        ROM_CTRL_CLK,
  input  wire logic        MAC_TX_EN,
  input  wire logic        MAC_RX_DV,
  input  wire logic        MAC_TX_CLK,
  input  wire logic        MAC_RX_CLK,
  output logic             ROM_DATA_OUT,
  output logic             ROM_DATA_OE,
  output logic             ROM_CLK_OUT,
  output logic             ROM_CLK_OE,
  input  wire logic        FRAME_DROPPED,
  output logic             TIMER_EVENT,
  output logic             DROP_HALF_EVENT
);

  // picks one 16-bit half of a register word
  function automatic logic [15:0] half_of(input logic [31:0] w, input logic hi);
    half_of = hi ? w[31:16] : w[15:0];
  endfunction

  // --------------------------------------------------------------------
  // host strobes: act once on the first cycle of each access
  logic        rd_act;
  logic        wr_act;
  logic        rd_act_reg;
  logic        wr_act_reg;
  logic        rd_go;
  logic        wr_go;
  logic        swapped;
  logic        half_hi;
  logic [7:0]  word_addr;

  assign rd_act    = !HOST_CS_N && !HOST_RD_N;
  assign wr_act    = !HOST_CS_N && !HOST_WR_N && HOST_RD_N;
  assign rd_go     = rd_act && !rd_act_reg;
  assign wr_go     = wr_act && !wr_act_reg;
  assign word_addr = {HOST_ADDR[7:2], 2'b00};

  // half select: plain order unless the swap pattern is held
  logic [31:0] word_order_reg;
  logic [31:0] word_order_next;
  assign swapped = (word_order_reg == mscsr_pkg::SWAP_PATTERN);
  assign half_hi = HOST_ADDR[1] ^ swapped;

  // --------------------------------------------------------------------
  // tick source and free-running counter
  logic        tick;
  logic [31:0] tick_count;

  mscsr_tick #(
    .DIV        (TICK_DIV)
  ) u_tick (
    .clk        (MCLK),
    .srst       (SRST),
    .tick       (tick),
    .tick_count (tick_count)
  );

  // --------------------------------------------------------------------
  // configuration state
  mscsr_pkg::mscsr_pin_cfg_type   pin_cfg_reg;
  mscsr_pkg::mscsr_pin_cfg_type   pin_cfg_next;
  mscsr_pkg::mscsr_tmr_state_type tmr_state_reg;
  mscsr_pkg::mscsr_tmr_state_type tmr_state_next;
  logic [15:0]                    preload_reg;
  logic [15:0]                    preload_next;
  logic [15:0]                    tmr_count_reg;
  logic [15:0]                    tmr_count_next;
  logic                           tmr_event_reg;
  logic                           tmr_event_next;
  logic                           run_wr;
  logic                           run_val;
  logic                           hi_wr;
  logic                           lo_wr;

  assign hi_wr   = wr_go && half_hi;
  assign lo_wr   = wr_go && !half_hi;
  assign run_wr  = hi_wr && (word_addr == mscsr_pkg::OFS_TIMER_CONFIG);
  assign run_val = HOST_DATA_IN[mscsr_pkg::TIMER_RUN_BIT - 16];

  // pin configuration and word order writes, one half per access
  always_comb begin
    pin_cfg_next    = pin_cfg_reg;
    word_order_next = word_order_reg;
    if (word_addr == mscsr_pkg::OFS_PIN_CONFIG && lo_wr) begin
      pin_cfg_next.pin_data_bit         = HOST_DATA_IN[mscsr_pkg::PIN_DATA_LSB +: 3];
      pin_cfg_next.output_only_data_bit = HOST_DATA_IN[mscsr_pkg::PIN_ODATA_LSB +: 2];
      pin_cfg_next.pin_direction_bit    = HOST_DATA_IN[mscsr_pkg::PIN_DIR_LSB +: 3];
    end
    if (word_addr == mscsr_pkg::OFS_PIN_CONFIG && hi_wr) begin
      pin_cfg_next.serial_rom_pin_select = HOST_DATA_IN[mscsr_pkg::ROM_SEL_LSB - 16 +: 3];
    end
    if (word_addr == mscsr_pkg::OFS_WORD_ORDER && lo_wr) begin
      word_order_next[15:0] = HOST_DATA_IN;
    end
    if (word_addr == mscsr_pkg::OFS_WORD_ORDER && hi_wr) begin
      word_order_next[31:16] = HOST_DATA_IN;
    end
  end

  // timer: run control, preload, countdown and event
  always_comb begin
    tmr_state_next = tmr_state_reg;
    preload_next   = preload_reg;
    tmr_count_next = tmr_count_reg;
    tmr_event_next = 1'b0;
    if (word_addr == mscsr_pkg::OFS_TIMER_CONFIG && lo_wr) begin
      preload_next = HOST_DATA_IN;
    end
    case (tmr_state_reg)
      mscsr_pkg::TMR_IDLE: begin
        if (run_wr && run_val) begin
          tmr_state_next = mscsr_pkg::TMR_RUN;
          tmr_count_next = preload_reg;
        end
      end
      mscsr_pkg::TMR_RUN: begin
        if (run_wr && !run_val) begin
          tmr_state_next = mscsr_pkg::TMR_IDLE;
          preload_next   = mscsr_pkg::PRELOAD_RESET;
        end else if (tick) begin
          if (tmr_count_reg == 16'h0000) begin
            tmr_count_next = preload_reg;
            tmr_event_next = 1'b1;
          end else begin
            tmr_count_next = tmr_count_reg - 16'h0001;
          end
        end
      end
      default: begin
        tmr_state_next = mscsr_pkg::TMR_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // coherent counter reads: the first half read latches the whole word
  logic        tick_pend_reg;
  logic        tick_pend_next;
  logic [31:0] tick_cap_reg;
  logic [31:0] tick_cap_next;
  logic        drop_pend_reg;
  logic        drop_pend_next;
  logic [31:0] drop_cap_reg;
  logic [31:0] drop_cap_next;
  logic [31:0] drop_cnt_reg;
  logic [31:0] drop_cnt_next;
  logic        drop_half_reg;
  logic        drop_half_next;
  logic        rd_tick;
  logic        rd_drop;

  assign rd_tick = rd_go && (word_addr == mscsr_pkg::OFS_TICK_COUNT);
  assign rd_drop = rd_go && (word_addr == mscsr_pkg::OFS_DROP_COUNT);

  // clearing on read of only the first half keeps the pair whole; a frame
  // dropped in the clearing cycle still counts, so nothing is lost
  always_comb begin
    tick_pend_next = tick_pend_reg;
    tick_cap_next  = tick_cap_reg;
    drop_pend_next = drop_pend_reg;
    drop_cap_next  = drop_cap_reg;
    drop_cnt_next  = drop_cnt_reg;
    drop_half_next = 1'b0;
    if (rd_tick) begin
      tick_pend_next = !tick_pend_reg;
      if (!tick_pend_reg) begin
        tick_cap_next = tick_count;
      end
    end
    if (rd_drop) begin
      drop_pend_next = !drop_pend_reg;
      if (!drop_pend_reg) begin
        drop_cap_next = drop_cnt_reg;
        drop_cnt_next = 32'h00000000;
      end
    end
    if (FRAME_DROPPED) begin
      drop_cnt_next = drop_cnt_next + 32'h00000001;
      if (drop_cnt_reg == mscsr_pkg::DROP_HALF_FROM &&
          drop_cnt_next == mscsr_pkg::DROP_HALF_TO) begin
        drop_half_next = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // read mux: words are built whole, then the selected half is returned
  logic [31:0] rd_word;
  logic [15:0] data_out_reg;
  logic [15:0] data_out_next;
  logic        data_oe_reg;
  logic        half_hi_reg;

  always_comb begin
    rd_word = 32'h00000000; // unmapped and reserved bits read zero
    case (word_addr)
      mscsr_pkg::OFS_PIN_CONFIG: begin
        rd_word[mscsr_pkg::PIN_DATA_LSB +: 3]  = GPIO_IN;
        rd_word[mscsr_pkg::PIN_ODATA_LSB +: 2] = pin_cfg_reg.output_only_data_bit;
        rd_word[mscsr_pkg::PIN_DIR_LSB +: 3]   = pin_cfg_reg.pin_direction_bit;
        rd_word[mscsr_pkg::ROM_SEL_LSB +: 3]   = pin_cfg_reg.serial_rom_pin_select;
      end
      mscsr_pkg::OFS_TIMER_CONFIG: begin
        rd_word[mscsr_pkg::TIMER_RUN_BIT] = (tmr_state_reg == mscsr_pkg::TMR_RUN);
        rd_word[15:0]                     = preload_reg;
      end
      mscsr_pkg::OFS_TIMER_COUNT: begin
        rd_word[15:0] = tmr_count_reg;
      end
      mscsr_pkg::OFS_WORD_ORDER: begin
        rd_word = word_order_reg;
      end
      mscsr_pkg::OFS_TICK_COUNT: begin
        rd_word = tick_pend_reg ? tick_cap_reg : tick_count;
      end
      mscsr_pkg::OFS_DROP_COUNT: begin
        rd_word = drop_pend_reg ? drop_cap_reg : drop_cnt_reg;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
    data_out_next = data_out_reg;
    if (rd_go) begin
      data_out_next = half_of(rd_word, half_hi);
    end
  end

  // --------------------------------------------------------------------
  // pin drive: the general pins and the routed ROM pins
  mscsr_pkg::mscsr_pin_drv_type rom_data_next;
  mscsr_pkg::mscsr_pin_drv_type rom_clk_next;
  mscsr_pkg::mscsr_pin_drv_type rom_data_reg;
  mscsr_pkg::mscsr_pin_drv_type rom_clk_reg;
  logic [2:0]                   gpio_out_reg;
  logic [2:0]                   gpio_oe_reg;

  // reserved codes leave both pins undriven rather than guess a function
  always_comb begin
    rom_data_next = '{level: 1'b0, enable: 1'b0};
    rom_clk_next  = '{level: 1'b0, enable: 1'b0};
    case (pin_cfg_reg.serial_rom_pin_select)
      mscsr_pkg::ROM_SEL_ROM: begin
        rom_data_next = '{level: ROM_CTRL_DATA, enable: ROM_CTRL_DATA_OE};
        rom_clk_next  = '{level: ROM_CTRL_CLK, enable: 1'b1};
      end
      mscsr_pkg::ROM_SEL_OUTS: begin
        rom_data_next = '{level: pin_cfg_reg.output_only_data_bit[0], enable: 1'b1};
        rom_clk_next  = '{level: pin_cfg_reg.output_only_data_bit[1], enable: 1'b1};
      end
      mscsr_pkg::ROM_SEL_OUT_RX: begin
        rom_data_next = '{level: pin_cfg_reg.output_only_data_bit[0], enable: 1'b1};
        rom_clk_next  = '{level: MAC_RX_DV, enable: 1'b1};
      end
      mscsr_pkg::ROM_SEL_TX_OUT: begin
        rom_data_next = '{level: MAC_TX_EN, enable: 1'b1};
        rom_clk_next  = '{level: pin_cfg_reg.output_only_data_bit[1], enable: 1'b1};
      end
      mscsr_pkg::ROM_SEL_TX_RX: begin
        rom_data_next = '{level: MAC_TX_EN, enable: 1'b1};
        rom_clk_next  = '{level: MAC_RX_DV, enable: 1'b1};
      end
      mscsr_pkg::ROM_SEL_CLOCKS: begin
        rom_data_next = '{level: MAC_TX_CLK, enable: 1'b1};
        rom_clk_next  = '{level: MAC_RX_CLK, enable: 1'b1};
      end
      default: begin
        rom_data_next = '{level: 1'b0, enable: 1'b0};
        rom_clk_next  = '{level: 1'b0, enable: 1'b0};
      end
    endcase
  end

  // --------------------------------------------------------------------
  // all state registers; the network side takes no part in the swap, so its
  // low-order-word-first order is fixed outside this block
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rd_act_reg     <= 1'b0;
      wr_act_reg     <= 1'b0;
      word_order_reg <= mscsr_pkg::WORD_ORDER_RST;
      pin_cfg_reg    <= '0;
      tmr_state_reg  <= mscsr_pkg::TMR_IDLE;
      preload_reg    <= mscsr_pkg::PRELOAD_RESET;
      tmr_count_reg  <= mscsr_pkg::COUNT_RESET;
      tmr_event_reg  <= 1'b0;
      tick_pend_reg  <= 1'b0;
      tick_cap_reg   <= 32'h00000000;
      drop_pend_reg  <= 1'b0;
      drop_cap_reg   <= 32'h00000000;
      drop_cnt_reg   <= 32'h00000000;
      drop_half_reg  <= 1'b0;
      data_out_reg   <= 16'h0000;
      data_oe_reg    <= 1'b0;
      half_hi_reg    <= 1'b0;
      gpio_out_reg   <= 3'h0;
      gpio_oe_reg    <= 3'h0;
      rom_data_reg   <= '0;
      rom_clk_reg    <= '0;
    end else begin
      rd_act_reg     <= rd_act;
      wr_act_reg     <= wr_act;
      word_order_reg <= word_order_next;
      pin_cfg_reg    <= pin_cfg_next;
      tmr_state_reg  <= tmr_state_next;
      preload_reg    <= preload_next;
      tmr_count_reg  <= tmr_count_next;
      tmr_event_reg  <= tmr_event_next;
      tick_pend_reg  <= tick_pend_next;
      tick_cap_reg   <= tick_cap_next;
      drop_pend_reg  <= drop_pend_next;
      drop_cap_reg   <= drop_cap_next;
      drop_cnt_reg   <= drop_cnt_next;
      drop_half_reg  <= drop_half_next;
      data_out_reg   <= data_out_next;
      data_oe_reg    <= rd_act;
      half_hi_reg    <= half_hi;
      gpio_out_reg   <= pin_cfg_reg.pin_data_bit;
      gpio_oe_reg    <= pin_cfg_reg.pin_direction_bit;
      rom_data_reg   <= rom_data_next;
      rom_clk_reg    <= rom_clk_next;
    end
  end

  assign HOST_DATA_OUT   = data_out_reg;
  assign HOST_DATA_OE    = data_oe_reg;
  assign HOST_HALF_HI    = half_hi_reg;
  assign GPIO_OUT        = gpio_out_reg;
  assign GPIO_OE         = gpio_oe_reg;
  assign ROM_DATA_OUT    = rom_data_reg.level;
  assign ROM_DATA_OE     = rom_data_reg.enable;
  assign ROM_CLK_OUT     = rom_clk_reg.level;
  assign ROM_CLK_OE      = rom_clk_reg.enable;
  assign TIMER_EVENT     = tmr_event_reg;
  assign DROP_HALF_EVENT = drop_half_reg;

endmodule
`default_nettype wire

// ==== verif/mscsr_asserts.sv ====
// port-level assertions for the miscellaneous register block
`timescale 1ns/1ps
`default_nettype none
module mscsr_asserts #(
  parameter int TICK_DIV = 8
) (
  input wire logic        MCLK,
  input wire logic        SRST,
  input wire logic        HOST_CS_N,
  input wire logic        HOST_RD_N,
  input wire logic        HOST_WR_N,
  input wire logic [15:0] HOST_DATA_OUT,
  input wire logic        HOST_DATA_OE,
  input wire logic [2:0]  GPIO_OUT,
  input wire logic [2:0]  GPIO_OE,
  input wire logic        FRAME_DROPPED,
  input wire logic        TIMER_EVENT,
  input wire logic        DROP_HALF_EVENT
);
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  logic        rd_on;
  logic        wr_on;
  // decoded strobes; a write with the read strobe low is no write
  assign rd_on = !HOST_CS_N && !HOST_RD_N;
  assign wr_on = !HOST_CS_N && !HOST_WR_N && HOST_RD_N;
  // cycles since the last timer event, saturating so it never wraps
  always_comb gap_next = TIMER_EVENT ? 16'h0000 : gap_reg + {15'h0000, gap_reg != 16'hffff};
  always_ff @(posedge MCLK) gap_reg <= SRST ? 16'hffff : gap_next;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  chk_oe_rise: assert property (rd_on |=> HOST_DATA_OE)
    else $error("read enable missing after strobe");
  chk_oe_fall: assert property (!rd_on |=> !HOST_DATA_OE)
    else $error("read enable without strobe");
  chk_out_hold: assert property (!$stable(HOST_DATA_OUT) |-> $past(rd_on))
    else $error("read data moved without a read");
  chk_dir_cause: assert property (!$stable(GPIO_OE) |-> $past(wr_on, 2) || $past(wr_on, 3))
    else $error("pin direction moved without a write");
  chk_data_cause: assert property (!$stable(GPIO_OUT) |-> $past(wr_on, 2) || $past(wr_on, 3))
    else $error("pin data moved without a write");
  chk_tmr_pulse: assert property (TIMER_EVENT |=> !TIMER_EVENT)
    else $error("timer event longer than one cycle");
  chk_tmr_gap: assert property (TIMER_EVENT |-> gap_reg >= TICK_DIV - 1)
    else $error("timer events closer than one tick");
  chk_drop_cause: assert property (DROP_HALF_EVENT |-> $past(FRAME_DROPPED) || $past(FRAME_DROPPED, 2))
    else $error("halfway event without a dropped frame");
  cover property (TIMER_EVENT);
  cover property (rd_on);
  cover property (!$stable(GPIO_OE));
endmodule
bind mscsr_top mscsr_asserts #(.TICK_DIV(TICK_DIV)) chk_i (
  .MCLK(MCLK), .SRST(SRST), .HOST_CS_N(HOST_CS_N), .HOST_RD_N(HOST_RD_N),
  .HOST_WR_N(HOST_WR_N), .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_OE(HOST_DATA_OE),
  .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .FRAME_DROPPED(FRAME_DROPPED),
  .TIMER_EVENT(TIMER_EVENT), .DROP_HALF_EVENT(DROP_HALF_EVENT));
`default_nettype wire

// ==== verif/mscsr_host.sv ====
// host processor model on the 16-bit register bus
`timescale 1ns/1ps
`default_nettype none
module mscsr_host (
  input  wire logic        MCLK,
  input  wire logic [15:0] HOST_DATA_OUT,
  output logic             HOST_CS_N,
  output logic             HOST_RD_N,
  output logic             HOST_WR_N,
  output logic [7:1]       HOST_ADDR,
  output logic [15:0]      HOST_DATA_IN
);
  // bus idle at time zero
  initial begin
    {HOST_CS_N, HOST_RD_N, HOST_WR_N} = 3'b111;
    {HOST_ADDR, HOST_DATA_IN} = '0;
  end
  // one access, entered at a rising edge; strobe held over the taking edge,
  // then one idle cycle, after which the registered read data is taken
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    {HOST_CS_N, HOST_RD_N, HOST_WR_N} <= {1'b0, wr, !wr};
    HOST_ADDR <= a[7:1];
    HOST_DATA_IN <= d;
    @(posedge MCLK);
    {HOST_CS_N, HOST_RD_N, HOST_WR_N} <= 3'b111;
    HOST_DATA_IN <= ~d; // released lines must not keep looking valid
    @(posedge MCLK);
    q = HOST_DATA_OUT;
  endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the miscellaneous register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TD = 2;
  localparam logic [15:0] ROUTE_VAL = 16'h90ca;
  localparam logic [15:0] ROUTE_OE = 16'hfccf;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cs_n, rd_n, wr_n, doe, hhi, drop, tev, dev;
  logic        rcd, rcdoe, rcc, txen, rxdv, txclk, rxclk, rdo, rdoe, rco, rcoe;
  logic [7:1]  addr;
  logic [15:0] din, dout;
  logic [2:0]  gin, gout, goe;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  mscsr_host host (.MCLK(clk), .HOST_DATA_OUT(dout), .HOST_CS_N(cs_n), .HOST_RD_N(rd_n),
    .HOST_WR_N(wr_n), .HOST_ADDR(addr), .HOST_DATA_IN(din));
  mscsr_top #(.TICK_DIV(TD)) uut (.MCLK(clk), .SRST(srst), .HOST_CS_N(cs_n), .HOST_RD_N(rd_n),
    .HOST_WR_N(wr_n), .HOST_ADDR(addr), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout),
    .HOST_DATA_OE(doe), .HOST_HALF_HI(hhi), .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE(goe),
    .ROM_CTRL_DATA(rcd), .ROM_CTRL_DATA_OE(rcdoe), .ROM_CTRL_CLK(rcc), .MAC_TX_EN(txen),
    .MAC_RX_DV(rxdv), .MAC_TX_CLK(txclk), .MAC_RX_CLK(rxclk), .ROM_DATA_OUT(rdo),
    .ROM_DATA_OE(rdoe), .ROM_CLK_OUT(rco), .ROM_CLK_OE(rcoe), .FRAME_DROPPED(drop),
    .TIMER_EVENT(tev), .DROP_HALF_EVENT(dev));
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    host.access(1'b0, a, 16'h0000, q);
    chk(name, exp, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    host.access(1'b1, a, d, q);
  endtask
  // reset values, reserved halves and an unmapped address
  task automatic t_reset();
    rdc("count_lo", 8'h90, 16'hffff);
    rdc("count_hi", 8'h92, 16'h0000);
    rdc("preload", 8'h8c, 16'hffff);
    rdc("run_half", 8'h8e, 16'h0000);
    rdc("swap_lo", 8'h98, 16'h0000);
    rdc("drop_lo", 8'ha0, 16'h0000);
    rdc("drop_hi", 8'ha2, 16'h0000);
    rdc("unmapped", 8'h80, 16'h0000);
  endtask
  // written data drives the pins, a read returns the pin levels instead
  task automatic t_gpio();
    gin <= 3'b010;
    wr(8'h88, 16'h0705);
    repeat (2) @(posedge clk);
    chk("gpio_oe", 16'h0007, {13'h0000, goe});
    chk("gpio_out", 16'h0005, {13'h0000, gout});
    rdc("gpio_read", 8'h88, 16'h0702);
  endtask
  // every select code, twice with all sources inverted; reserved codes float
  task automatic t_route();
    logic       oe_d;
    logic       oe_c;
    logic [3:0] e;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        {rcd, rcdoe, rcc, txen, rxdv, txclk, rxclk} <= (p == 1) ? 7'h19 : 7'h66;
        wr(8'h88, (p == 1) ? 16'h0010 : 16'h0008);
        wr(8'h8a, 16'(k << 4));
        repeat (2) @(posedge clk);
        oe_d = ROUTE_OE[2*k+1] & !(k == 0 && p == 1);
        oe_c = ROUTE_OE[2*k];
        e = {(ROUTE_VAL[2*k+1] ^ p[0]) & oe_d, oe_d, (ROUTE_VAL[2*k] ^ p[0]) & oe_c, oe_c};
        chk("rom_pins", {12'h000, e}, {12'h000, rdo & rdoe, rdoe, rco & rcoe, rcoe});
      end
    end
  endtask
  // reload period, zero high half of the count while running, halt presets the preload and silences events
  task automatic t_timer();
    int n;
    wr(8'h8c, 16'h0003);
    wr(8'h8e, 16'h2000);
    n = 0;
    while (tev !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tev !== 1'b1 && n < 200);
    chk("timer_period", 16'(4 * TD), 16'(n));
    rdc("count_hi_run", 8'h92, 16'h0000);
    wr(8'h8e, 16'h0000);
    rdc("preload_halt", 8'h8c, 16'hffff);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += (tev === 1'b1);
    end
    chk("halt_events", 16'h0000, 16'(n));
  endtask
  // five frames, a coherent pair, then the clear left by the read
  task automatic t_drop();
    drop <= 1'b1;
    repeat (5) @(posedge clk);
    drop <= 1'b0;
    rdc("drop_count", 8'ha0, 16'h0005);
    rdc("drop_pair", 8'ha2, 16'h0000);
    rdc("drop_clear", 8'ha0, 16'h0000);
    rdc("drop_clear_hi", 8'ha2, 16'h0000);
    // a handful of frames is far from the halfway point, so no event may show
    chk("drop_half_idle", 16'h0000, {15'h0000, dev});
  endtask
  // second read of a pair is the captured word; takes 24 cycles apart
  task automatic t_tick();
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    host.access(1'b0, 8'h9c, 16'h0000, a);
    repeat (20) @(posedge clk);
    rdc("tick_pair", 8'h9c, a);
    host.access(1'b0, 8'h9c, 16'h0000, b);
    host.access(1'b0, 8'h9e, 16'h0000, c);
    chk("tick_step", 16'(24 / TD), b - a);
    chk("tick_hi", 16'h0000, c);
  endtask
  // the all-ones pattern reverses the halves, anything else does not
  task automatic t_swap();
    wr(8'h98, 16'hffff);
    wr(8'h9a, 16'hffff);
    rdc("swap_low_addr", 8'h8c, 16'h0000);
    // address still stands after the access, so the half select shows the swap
    chk("half_hi_swap", 16'h0001, {15'h0000, hhi});
    rdc("swap_high_addr", 8'h8e, 16'hffff);
    wr(8'h98, 16'h0000);
    rdc("unswap", 8'h8c, 16'hffff);
    chk("half_hi_plain", 16'h0000, {15'h0000, hhi});
  endtask
  // reset for four cycles, then every scenario in turn
  initial begin
    {rcd, rcdoe, rcc, txen, rxdv, txclk, rxclk} = 7'h66;
    gin = 3'b000;
    drop = 1'b0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_gpio();
    t_route();
    t_timer();
    t_drop();
    t_tick();
    t_swap();
    final_report();
  end
endmodule
`default_nettype wire
